// ===== include/csg_defs.vh
// Constants for the clocked split-group digital port
`ifndef CSG_DEFS_VH
`define CSG_DEFS_VH
`define CSG_LINES        8
`define CSG_TBUS_LINES   8
`define CSG_TBUS_SEL_W   3
`define CSG_DEPTH        8
`define CSG_PTR_W        3
`define CSG_CNT_W        4
`define CSG_RST_BYTE     8'h00
`define CSG_DIR_IN       1'b0
`define CSG_DIR_OUT      1'b1
`endif

// ===== core/csg_edge_det.v
// Synchroniser and selectable edge detector for the group clock
`timescale 1ns/1ps
`include "csg_defs.vh"
module csg_edge_det (
    input  wire                          clk_in,
    input  wire                          rst_n_in,
    input  wire [`CSG_TBUS_LINES-1:0]    tbus_in,
    input  wire [`CSG_TBUS_SEL_W-1:0]    sel_in,
    input  wire                          fall_in,
    output reg                           tick_out
);
    reg  [`CSG_TBUS_LINES-1:0] sync1_ff;
    reg  [`CSG_TBUS_LINES-1:0] sync2_ff;
    reg                        prev_ff;
    wire                       cur;
    wire                       nxt_tick;

    assign cur = sync2_ff[sel_in];
    // Rising or falling edge of the selected, synchronised line
    assign nxt_tick = fall_in ? (prev_ff & ~cur) : (~prev_ff & cur);

    // Two-stage synchroniser, previous sample and edge pulse
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1_ff <= {`CSG_TBUS_LINES{1'b0}};
            sync2_ff <= {`CSG_TBUS_LINES{1'b0}};
            prev_ff  <= 1'b0;
            tick_out <= 1'b0;
        end else begin
            sync1_ff <= tbus_in;
            sync2_ff <= sync1_ff;
            prev_ff  <= cur;
            tick_out <= nxt_tick;
        end
    end
endmodule // csg_edge_det

// ===== core/csg_port.v
// Eight-line port split into one clocked input group and one clocked output group
// How it works
// R1 - Port splits into group one and group two, one input, one output.
// R2 - Any subset of lines 0-7 may form a group, contiguous or not.
// R3 - Lines outside both groups stay usable for immediate unclocked reads and writes.
// R4 - Setting both groups to the same direction is refused.
// R5 - Group data is an 8-bit word, each bit at its own line position.
// R6 - Grouped lines move data only through buffered, clock-paced transfers.
// R7 - No per-transfer status flag for captured or driven values.
// R8 - Output group drives next buffered value on the selected clock edge.
// R9 - Input group samples its lines into the buffer on the selected edge.
// R10 - Edge select chooses rising or falling edge of the group clock.
// R11 - Group clock arrives on one of the shared timing bus lines.
// R12 - No request or acknowledge handshake; only clock edges pace data.
// R13 - Empty output buffer holds last value; full input buffer flags overrun.
`timescale 1ns/1ps
`include "csg_defs.vh"
module csg_port (
    input  wire                          REF_CLK_IN,
    input  wire                          RESET_N_IN,
    input  wire [`CSG_LINES-1:0]         GRP1_MASK_IN,
    input  wire [`CSG_LINES-1:0]         GRP2_MASK_IN,
    input  wire                          GRP1_DIR_IN,
    input  wire                          GRP2_DIR_IN,
    input  wire                          CFG_WR_IN,
    input  wire                          RUN_IN,
    input  wire [`CSG_TBUS_LINES-1:0]    SHARED_TIMING_BUS_LINE_IN,
    input  wire [`CSG_TBUS_SEL_W-1:0]    TBUS_SEL_IN,
    input  wire                          EDGE_FALL_IN,
    input  wire [`CSG_LINES-1:0]         IMM_DIR_IN,
    input  wire [`CSG_LINES-1:0]         IMM_DATA_IN,
    input  wire [`CSG_LINES-1:0]         WR_DATA_IN,
    input  wire                          WR_VALID_IN,
    output reg                           WR_READY_OUT,
    output reg  [`CSG_LINES-1:0]         RD_DATA_OUT,
    output reg                           RD_VALID_OUT,
    input  wire                          RD_READY_IN,
    input  wire                          OVR_CLR_IN,
    output reg                           OVERRUN_OUT,
    output reg                           CFG_ERR_OUT,
    output reg  [`CSG_LINES-1:0]         IMM_RD_OUT,
    input  wire [`CSG_LINES-1:0]         LINE_IN,
    output reg  [`CSG_LINES-1:0]         LINE_OUT,
    output reg  [`CSG_LINES-1:0]         LINE_OE_N_OUT
);
    reg  [`CSG_LINES-1:0] in_mask_ff;
    reg  [`CSG_LINES-1:0] out_mask_ff;
    reg  [`CSG_LINES-1:0] line_s1_ff;
    reg  [`CSG_LINES-1:0] line_s2_ff;
    reg  [`CSG_LINES-1:0] grp_val_ff;
    reg  [`CSG_LINES-1:0] ob_mem_ff [0:`CSG_DEPTH-1];
    reg  [`CSG_LINES-1:0] ib_mem_ff [0:`CSG_DEPTH-1];
    reg  [`CSG_PTR_W-1:0] ob_wp_ff;
    reg  [`CSG_PTR_W-1:0] ob_rp_ff;
    reg  [`CSG_CNT_W-1:0] ob_cnt_ff;
    reg  [`CSG_PTR_W-1:0] ib_wp_ff;
    reg  [`CSG_PTR_W-1:0] ib_rp_ff;
    reg  [`CSG_CNT_W-1:0] ib_cnt_ff;
    wire                  tick;
    wire                  cfg_bad;
    wire                  ob_push;
    wire                  ob_pop;
    wire                  ib_push;
    wire                  ib_pop;
    wire                  ib_full;
    wire [`CSG_CNT_W-1:0] nxt_ob_cnt;
    wire [`CSG_CNT_W-1:0] nxt_ib_cnt;
    wire [`CSG_LINES-1:0] grp_mask;
    integer               i;
    genvar                g;
    wire [`CSG_PTR_W-1:0] nxt_head;
    wire [`CSG_LINES-1:0] in_word;
    wire [`CSG_LINES-1:0] nxt_rd_data;
    wire [`CSG_LINES-1:0] nxt_line_out;
    wire [`CSG_LINES-1:0] nxt_line_oe_n;
    wire [`CSG_LINES-1:0] nxt_imm_rd;
    wire                  ib_drop;

    // Pointer step at pointer width, so no addition widens silently
    localparam [`CSG_PTR_W-1:0] ptr_one = {{(`CSG_PTR_W-1){1'b0}}, 1'b1};

    // True when the requested directions clash or the masks overlap
    function cfg_clash;
        input                  d1;
        input                  d2;
        input [`CSG_LINES-1:0] m1;
        input [`CSG_LINES-1:0] m2;
        begin
            cfg_clash = (d1 == d2) | (|(m1 & m2));
        end
    endfunction

    // Group clock from the chosen shared timing bus line, chosen edge
    csg_edge_det u_edge (
        .clk_in   (REF_CLK_IN),
        .rst_n_in (RESET_N_IN),
        .tbus_in  (SHARED_TIMING_BUS_LINE_IN), // R11
        .sel_in   (TBUS_SEL_IN),
        .fall_in  (EDGE_FALL_IN),               // R10
        .tick_out (tick)
    );

    assign cfg_bad  = cfg_clash(GRP1_DIR_IN, GRP2_DIR_IN, GRP1_MASK_IN, GRP2_MASK_IN); // R4
    assign grp_mask = in_mask_ff | out_mask_ff;
    // Buffer movements: host side by valid/ready, group side paced only by detected clock edges
    assign ob_push  = WR_VALID_IN & WR_READY_OUT;
    assign ob_pop   = tick & RUN_IN & (ob_cnt_ff != {`CSG_CNT_W{1'b0}}); // R8 R12 R13
    assign ib_full  = (ib_cnt_ff == `CSG_DEPTH);
    assign ib_push  = tick & RUN_IN & (|in_mask_ff) & ~ib_full; // R9 R12 R13
    assign ib_pop   = RD_VALID_OUT & RD_READY_IN;
    assign nxt_ob_cnt = ob_cnt_ff + {{(`CSG_CNT_W-1){1'b0}}, ob_push} - {{(`CSG_CNT_W-1){1'b0}}, ob_pop};
    assign nxt_ib_cnt = ib_cnt_ff + {{(`CSG_CNT_W-1){1'b0}}, ib_push} - {{(`CSG_CNT_W-1){1'b0}}, ib_pop};
    // Edge found the input buffer full: the sample is dropped
    assign ib_drop  = tick & RUN_IN & (|in_mask_ff) & ib_full; // R13
    // Captured word: grouped input lines only, each at its own position
    assign in_word  = line_s2_ff & in_mask_ff; // R5 R9
    // Head slot of the input buffer after this cycle's pop
    assign nxt_head = ib_pop ? (ib_rp_ff + ptr_one) : ib_rp_ff;
    // A word landing in the head slot is forwarded, since the slot is not written yet
    assign nxt_rd_data = (ib_push && (nxt_head == ib_wp_ff)) ? in_word : ib_mem_ff[nxt_head];

    // Per-line pin decode: grouped lines clocked, the others immediate
    generate
        for (g = 0; g < `CSG_LINES; g = g + 1) begin : g_line
            assign nxt_line_out[g]  = out_mask_ff[g] ? grp_val_ff[g] : (~grp_mask[g] & IMM_DATA_IN[g]); // R3 R8
            assign nxt_line_oe_n[g] = ~(out_mask_ff[g] | (~grp_mask[g] & IMM_DIR_IN[g]));
            assign nxt_imm_rd[g]    = ~grp_mask[g] & line_s2_ff[g]; // R3
        end
    endgenerate

    // Group configuration; a clashing setting is refused and flagged
    always @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            in_mask_ff  <= {`CSG_LINES{1'b0}};
            out_mask_ff <= {`CSG_LINES{1'b0}};
            CFG_ERR_OUT <= 1'b0;
        end else if (CFG_WR_IN) begin
            CFG_ERR_OUT <= cfg_bad; // R4
            if (!cfg_bad) begin
                // R1 R2
                in_mask_ff  <= (GRP1_DIR_IN == `CSG_DIR_IN) ? GRP1_MASK_IN : GRP2_MASK_IN;
                out_mask_ff <= (GRP1_DIR_IN == `CSG_DIR_OUT) ? GRP1_MASK_IN : GRP2_MASK_IN;
            end
        end
    end

    // Line synchroniser
    always @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            line_s1_ff <= {`CSG_LINES{1'b0}};
            line_s2_ff <= {`CSG_LINES{1'b0}};
        end else begin
            line_s1_ff <= LINE_IN;
            line_s2_ff <= line_s1_ff;
        end
    end

    // Output buffer: value held until the next edge finds data
    always @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            ob_wp_ff     <= {`CSG_PTR_W{1'b0}};
            ob_rp_ff     <= {`CSG_PTR_W{1'b0}};
            ob_cnt_ff    <= {`CSG_CNT_W{1'b0}};
            grp_val_ff   <= `CSG_RST_BYTE;
            WR_READY_OUT <= 1'b0;
            for (i = 0; i < `CSG_DEPTH; i = i + 1) begin
                ob_mem_ff[i] <= `CSG_RST_BYTE;
            end
        end else begin
            if (ob_push) begin
                ob_mem_ff[ob_wp_ff] <= WR_DATA_IN; // R5
                ob_wp_ff            <= ob_wp_ff + ptr_one;
            end
            if (ob_pop) begin
                grp_val_ff <= ob_mem_ff[ob_rp_ff]; // R8 R13
                ob_rp_ff   <= ob_rp_ff + ptr_one;
            end
            ob_cnt_ff    <= nxt_ob_cnt;
            WR_READY_OUT <= (nxt_ob_cnt < `CSG_DEPTH);
        end
    end

    // Input buffer and sticky overrun flag; a new overrun beats the clear
    always @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            ib_wp_ff     <= {`CSG_PTR_W{1'b0}};
            ib_rp_ff     <= {`CSG_PTR_W{1'b0}};
            ib_cnt_ff    <= {`CSG_CNT_W{1'b0}};
            OVERRUN_OUT  <= 1'b0;
            RD_VALID_OUT <= 1'b0;
            RD_DATA_OUT  <= `CSG_RST_BYTE;
            for (i = 0; i < `CSG_DEPTH; i = i + 1) begin
                ib_mem_ff[i] <= `CSG_RST_BYTE;
            end
        end else begin
            if (ib_push) begin
                ib_mem_ff[ib_wp_ff] <= in_word; // R5 R9
                ib_wp_ff            <= ib_wp_ff + ptr_one;
            end
            if (ib_pop) begin
                ib_rp_ff <= ib_rp_ff + ptr_one;
            end
            ib_cnt_ff <= nxt_ib_cnt;
            if (ib_drop) begin
                OVERRUN_OUT <= 1'b1; // R13
            end else if (OVR_CLR_IN) begin
                OVERRUN_OUT <= 1'b0;
            end
            // Head of buffer presented registered, one word at a time
            RD_VALID_OUT <= (nxt_ib_cnt != {`CSG_CNT_W{1'b0}});
            RD_DATA_OUT  <= nxt_rd_data;
        end
    end

    // Pin drive: grouped lines clocked, others immediate
    always @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            LINE_OUT      <= {`CSG_LINES{1'b0}};
            LINE_OE_N_OUT <= {`CSG_LINES{1'b1}};
            IMM_RD_OUT    <= {`CSG_LINES{1'b0}};
        end else begin
            // R6 R7
            LINE_OUT      <= nxt_line_out; // R3
            LINE_OE_N_OUT <= nxt_line_oe_n;
            IMM_RD_OUT    <= nxt_imm_rd; // R3
        end
    end
endmodule // csg_port

// ===== bench/csg_port_props.sv
// Concurrent checks on the ports of the split-group digital port
`timescale 1ns/1ps
`include "csg_defs.vh"
module csg_port_props (
    input wire                  REF_CLK_IN,
    input wire                  RESET_N_IN,
    input wire [`CSG_LINES-1:0] GRP1_MASK_IN,
    input wire [`CSG_LINES-1:0] GRP2_MASK_IN,
    input wire                  GRP1_DIR_IN,
    input wire                  GRP2_DIR_IN,
    input wire                  CFG_WR_IN,
    input wire                  RUN_IN,
    input wire [`CSG_TBUS_LINES-1:0] SHARED_TIMING_BUS_LINE_IN,
    input wire                  RD_READY_IN,
    input wire                  OVR_CLR_IN,
    input wire [`CSG_LINES-1:0] RD_DATA_OUT,
    input wire                  RD_VALID_OUT,
    input wire                  OVERRUN_OUT,
    input wire                  CFG_ERR_OUT,
    input wire [`CSG_LINES-1:0] LINE_OUT
);
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RESET_N_IN);
    // Configuration answers
    chk_dir_refuse: assert property (CFG_WR_IN && GRP1_DIR_IN == GRP2_DIR_IN |=> CFG_ERR_OUT)
        else $error("same-direction setting accepted");
    chk_cfg_accept: assert property (CFG_WR_IN && GRP1_DIR_IN != GRP2_DIR_IN
        && (GRP1_MASK_IN & GRP2_MASK_IN) == 8'h00 |=> !CFG_ERR_OUT)
        else $error("legal split refused");
    chk_err_hold: assert property (!CFG_WR_IN |=> $stable(CFG_ERR_OUT))
        else $error("config error flag moved without a write");
    // Buffer and overrun behaviour
    chk_ovr_sticky: assert property (OVERRUN_OUT && !OVR_CLR_IN |=> OVERRUN_OUT)
        else $error("overrun flag lost without clear");
    chk_rd_hold: assert property (RD_VALID_OUT && !RD_READY_IN |=> RD_VALID_OUT && $stable(RD_DATA_OUT))
        else $error("input word changed before it was taken");
    chk_word_unpacked: assert property (RD_VALID_OUT |-> (RD_DATA_OUT & ~(GRP1_MASK_IN | GRP2_MASK_IN)) == 8'h00)
        else $error("ungrouped bit set in input word");
    // Group data moves only when the group clock moves
    chk_idle_no_rd: assert property (($stable(SHARED_TIMING_BUS_LINE_IN) && RUN_IN) [*8] |-> !$rose(RD_VALID_OUT))
        else $error("input word stored without a clock edge");
    chk_idle_no_out: assert property (($stable(SHARED_TIMING_BUS_LINE_IN) && RUN_IN) [*8] |-> $stable(LINE_OUT))
        else $error("output lines changed without a clock edge");
endmodule // csg_port_props
bind csg_port csg_port_props u_props (.REF_CLK_IN, .RESET_N_IN, .GRP1_MASK_IN, .GRP2_MASK_IN, .GRP1_DIR_IN,
    .GRP2_DIR_IN, .CFG_WR_IN, .RUN_IN, .SHARED_TIMING_BUS_LINE_IN, .RD_READY_IN, .OVR_CLR_IN, .RD_DATA_OUT,
    .RD_VALID_OUT, .OVERRUN_OUT, .CFG_ERR_OUT, .LINE_OUT);

// ===== bench/csg_far_end.sv
// External equipment: timing pulse source and line driver
`timescale 1ns/1ps
module csg_far_end (
    input  wire       clk_in,
    input  wire       pulse_in,
    input  wire [2:0] sel_in,
    input  wire       fall_in,
    input  wire [7:0] pat_in,
    input  wire [7:0] line_out_in,
    input  wire [7:0] oe_n_in,
    output wire [7:0] tbus_out,
    output wire [7:0] line_in_out
);
    reg [7:0] drv_ff = 8'h00;
    // Clock on one timing line only, low between pulses
    assign tbus_out = pulse_in ? (8'h01 << sel_in) : 8'h00;
    // Own data changes only away from the active edge
    always @(posedge clk_in) if (pulse_in == fall_in) drv_ff <= pat_in;
    // Wire level: device where it drives, equipment elsewhere
    assign line_in_out = (~oe_n_in & line_out_in) | (oe_n_in & drv_ff);
endmodule // csg_far_end

// ===== bench/csg_port_test.sv
// Self-checking bench for the split-group digital port
`timescale 1ns/1ps
`include "csg_defs.vh"
module csg_port_test;
    reg clk = 0, rst_n = 0, cfg_wr = 0, run = 0, fall = 0, wr_valid = 0, rd_ready = 1, ovr_clr = 0, d1 = 0, d2 = 1;
    reg pulse = 0;
    reg [7:0] m1 = 0, m2 = 0, wr_data = 0, pat = 0, imm_dir = 8'h10, imm_data = 8'h10, w, outw [0:7];
    reg [2:0] sel = 0;
    reg [31:0] lfsr = 32'h6393f549;
    wire [7:0] tbus, line_in, line_out, oe_n, rd_data, imm_rd;
    wire wr_ready, rd_valid, ovr, cfg_err;
    integer bad_count = 0, total_checks = 0, i, k;
    reg [7:0] exp_q [$];
    csg_port dut (.REF_CLK_IN(clk), .RESET_N_IN(rst_n), .GRP1_MASK_IN(m1), .GRP2_MASK_IN(m2), .GRP1_DIR_IN(d1),
        .GRP2_DIR_IN(d2), .CFG_WR_IN(cfg_wr), .RUN_IN(run), .SHARED_TIMING_BUS_LINE_IN(tbus), .TBUS_SEL_IN(sel),
        .EDGE_FALL_IN(fall), .IMM_DIR_IN(imm_dir), .IMM_DATA_IN(imm_data), .WR_DATA_IN(wr_data),
        .WR_VALID_IN(wr_valid), .WR_READY_OUT(wr_ready), .RD_DATA_OUT(rd_data), .RD_VALID_OUT(rd_valid),
        .RD_READY_IN(rd_ready), .OVR_CLR_IN(ovr_clr), .OVERRUN_OUT(ovr), .CFG_ERR_OUT(cfg_err),
        .IMM_RD_OUT(imm_rd), .LINE_IN(line_in), .LINE_OUT(line_out), .LINE_OE_N_OUT(oe_n));
    csg_far_end far (.clk_in(clk), .pulse_in(pulse), .sel_in(sel), .fall_in(fall), .pat_in(pat),
        .line_out_in(line_out), .oe_n_in(oe_n), .tbus_out(tbus), .line_in_out(line_in));
    always #5 clk = ~clk;
    function [31:0] nxt(input [31:0] s);
        nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task check(input [7:0] seen, input [7:0] want, input [8*8:1] what);
        begin
            total_checks = total_checks + 1;
            if (seen !== want) begin
                bad_count = bad_count + 1;
                $display("[FAIL] %0t %0s seen %h want %h", $time, what, seen, want);
            end
        end
    endtask
    task cfg(input a, input b, input [7:0] x, input [7:0] y, input e);
        begin
            d1 = a; d2 = b; m1 = x; m2 = y; cfg_wr = 1;
            @(negedge clk) cfg_wr = 0;
            @(negedge clk) check({7'h00, cfg_err}, {7'h00, e}, "cfg");
        end
    endtask
    // One group clock pulse: one active edge in either mode
    task tick;
        begin
            @(negedge clk) pulse = 1;
            repeat (8) @(negedge clk);
            pulse = 0;
            repeat (8) @(negedge clk);
        end
    endtask
    task final_report;
        begin
            $display("checks %0d mismatches %0d", total_checks, bad_count);
            if (bad_count == 0 && total_checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    // Watcher: each input word taken is compared with the oldest note
    always @(posedge clk)
        if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
            w = exp_q.size() ? exp_q.pop_front() : ~rd_data;
            check(rd_data, w, "inword");
        end
    // Watchdog well beyond the expected run
    initial begin
        #100000 bad_count = bad_count + 1;
        final_report;
    end
    // Main sequence
    initial begin
        repeat (11) @(negedge clk);
        check(oe_n, 8'hff, "rstoe");
        @(negedge clk) rst_n = 1;
        cfg(0, 0, 8'h01, 8'h02, 1);
        cfg(1, 1, 8'h01, 8'h02, 1);
        cfg(1, 0, 8'h03, 8'h06, 1);
        check(oe_n, 8'hef, "keep");
        for (k = 0; k < 2; k = k + 1) begin
            fall = k; sel = 3'h2 + 3 * k;
            if (k) cfg(0, 1, 8'h05, 8'haa, 0); else cfg(1, 0, 8'haa, 8'h05, 0);
            repeat (4) @(negedge clk);
            check(oe_n, 8'h45, "drive");
            check(imm_rd, (far.drv_ff & 8'h40) | 8'h10, "imm");
            for (i = 0; i < 8; i = i + 1) begin
                lfsr = nxt(lfsr); outw[i] = lfsr[7:0]; wr_data = lfsr[7:0]; wr_valid = 1;
                @(negedge clk);
            end
            wr_valid = 0;
            check({7'h00, wr_ready}, 8'h00, "full");
            rd_ready = k; run = 1;
            for (i = 0; i < 10; i = i + 1) begin
                lfsr = nxt(lfsr); pat = lfsr[7:0];
                if (k || i < 8) exp_q.push_back(pat & 8'h05);
                tick;
                check(line_out & 8'haa, outw[i < 8 ? i : 7] & 8'haa, "out");
            end
            check({7'h00, ovr}, {7'h00, !k}, "ovr");
            rd_ready = 1;
            repeat (12) @(negedge clk);
            check(exp_q.size(), 8'h00, "drain");
            ovr_clr = 1;
            @(negedge clk) ovr_clr = 0;
            @(negedge clk) check({7'h00, ovr}, 8'h00, "ovrclr");
            run = 0;
            $display("test %0d done", k);
        end
        final_report;
    end
endmodule // csg_port_test
